//--- core/pba_pkg.sv
// package: constants and carriers for the packet buffer access port
package pba_pkg;

  // buffer geometry
  localparam int unsigned PBA_ADDR_W = 13;
  localparam int unsigned PBA_DEPTH = 8192;
  localparam int unsigned PBA_DATA_W = 8;

  // register offsets in the core's register space (12-bit address)
  localparam logic [11:0] PBA_OFS_DATA_WINDOW = 12'hF61;
  localparam logic [11:0] PBA_OFS_RDPT_L = 12'hF62;
  localparam logic [11:0] PBA_OFS_RDPT_H = 12'hF63;
  localparam logic [11:0] PBA_OFS_WRPT_L = 12'hF64;
  localparam logic [11:0] PBA_OFS_WRPT_H = 12'hF65;
  localparam logic [11:0] PBA_OFS_RXST_L = 12'hF66;
  localparam logic [11:0] PBA_OFS_RXST_H = 12'hF67;
  localparam logic [11:0] PBA_OFS_RXND_L = 12'hF68;
  localparam logic [11:0] PBA_OFS_RXND_H = 12'hF69;
  localparam logic [11:0] PBA_OFS_CTRL_TWO = 12'hF6A;

  // field positions of module_control_two
  localparam int unsigned PBA_CTL_POINTER_AUTO_INCREMENT_BIT = 7;
  localparam int unsigned PBA_CTL_ENABLE_BIT = 5;

  // reset values and the one-step pointer increment
  localparam logic [7:0] PBA_CTRL_TWO_RST = 8'h80;
  localparam logic [12:0] PBA_PTR_RST = 13'h0000;
  localparam logic [12:0] PBA_RXND_RST = 13'h1FFF;
  localparam logic [12:0] PBA_PTR_ONE = 13'h0001;

  // access kinds seen on the register bus
  typedef enum logic [1:0] {
    PBA_ACC_NONE = 2'b00,
    PBA_ACC_READ = 2'b01,
    PBA_ACC_WRITE = 2'b10,
    PBA_ACC_RMW = 2'b11
  } pba_acc_e;

  // one register bus request from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic single_cycle;
    logic [11:0] addr;
    logic [7:0] wdata;
  } pba_req_s;

  // pointer set steering the window
  typedef struct packed {
    logic [12:0] rdpt;
    logic [12:0] wrpt;
    logic [12:0] rxst;
    logic [12:0] rxnd;
  } pba_ptrs_s;

endpackage : pba_pkg

//--- core/pba_buffer_ram.sv
// file: flip-flop storage for the 8 Kbyte packet buffer
`timescale 1ns/1ps
module pba_buffer_ram
  import pba_pkg::*;
(
  // clocking
  input wire logic clk_sys_i,
  input wire logic ce_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [12:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  // read port
  input wire logic [12:0] rd_addr_i,
  output logic [7:0] rd_data_o
);

  // storage array, one byte per address, no reset on contents
  logic [7:0] mem_q [PBA_DEPTH];

  // write port; a frozen clock enable also freezes the contents
  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (wr_en_i) begin
        mem_q[wr_addr_i] <= wr_data_i;
      end
    end
  end

  // plain read of the flops: the port registers the byte itself, so
  // the bus output still leaves from a flip-flop
  assign rd_data_o = mem_q[rd_addr_i];

endmodule // pba_buffer_ram

//--- core/pba_access_port.sv
// file: top of the packet buffer access port behind the register bus
`timescale 1ns/1ps
module pba_access_port
  import pba_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // core register bus
  input wire logic bus_rd_i,
  input wire logic bus_wr_i,
  input wire logic bus_single_cycle_i,
  input wire logic [11:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  output logic [7:0] bus_rdata_o,
  output logic bus_rvalid_o,
  // physical-layer register bank, word access
  input wire logic phy_wr_i,
  input wire logic [4:0] phy_addr_i,
  input wire logic [15:0] phy_wdata_i,
  output logic [15:0] phy_rdata_o,
  // status out
  output logic module_enable_o,
  output logic window_busy_o
);

  // request bundle
  pba_req_s req;
  assign req = '{rd: bus_rd_i, wr: bus_wr_i,
                 single_cycle: bus_single_cycle_i,
                 addr: bus_addr_i, wdata: bus_wdata_i};

  // pointer and control state
  pba_ptrs_s ptrs_q, ptrs_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [15:0] phy_bank_q [32];
  logic [15:0] phy_rdata_q;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic win_rd_q, win_rd_d;
  logic busy_q, busy_d;

  // buffer ports
  logic ram_we;
  logic [7:0] ram_rdata;

  // plain linear step, 13 bits wide so the top address rolls to zero
  function automatic logic [12:0] step_ptr(input logic [12:0] p);
    step_ptr = p + PBA_PTR_ONE;
  endfunction

  // read-side advance: end of receive region returns to its start
  function automatic logic [12:0] step_rd(input logic [12:0] p,
                                          input logic [12:0] st,
                                          input logic [12:0] nd);
    if (p == nd) begin
      step_rd = st;
    end else begin
      step_rd = step_ptr(p);
    end
  endfunction

  // set a byte lane of a 13-bit pointer
  function automatic logic [12:0] set_lo(input logic [12:0] p,
                                         input logic [7:0] b);
    set_lo = {p[12:8], b};
  endfunction
  function automatic logic [12:0] set_hi(input logic [12:0] p,
                                         input logic [7:0] b);
    set_hi = {b[4:0], p[7:0]};
  endfunction

  // decode
  logic hit_win;
  logic win_rd;
  logic win_wr;
  logic pointer_auto_increment;
  pba_acc_e acc;
  assign hit_win = (req.addr == PBA_OFS_DATA_WINDOW);
  assign win_rd = hit_win && req.rd && !req.wr;
  assign win_wr = hit_win && req.wr && !req.rd;
  assign pointer_auto_increment = ctrl_q[PBA_CTL_POINTER_AUTO_INCREMENT_BIT];
  assign acc = pba_acc_e'({req.wr, req.rd});
  // window accesses use the buffer directly, no arbiter stall
  assign ram_we = win_wr;

  // buffer, addressed by the pointers only
  pba_buffer_ram u_ram (
    .clk_sys_i(clk_sys_i),
    .ce_i(ce_i),
    .wr_en_i(ram_we),
    .wr_addr_i(ptrs_q.wrpt),
    .wr_data_i(req.wdata),
    .rd_addr_i(ptrs_q.rdpt),
    .rd_data_o(ram_rdata)
  );

  // next-state for pointers, control and read data
  always_comb begin
    ptrs_d = ptrs_q;
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    win_rd_d = 1'b0;
    busy_d = 1'b0;
    // enable bit plays no part in access: buffer works either way
    unique case (acc)
      PBA_ACC_READ: begin
        rvalid_d = 1'b1;
        win_rd_d = hit_win;
        busy_d = hit_win;
        if (win_rd && pointer_auto_increment) begin
          ptrs_d.rdpt = step_rd(ptrs_q.rdpt, ptrs_q.rxst,
                                ptrs_q.rxnd);
        end
        // no auto-increment: pointer holds
        unique case (req.addr)
          PBA_OFS_RDPT_L: rdata_d = ptrs_q.rdpt[7:0];
          PBA_OFS_RDPT_H: rdata_d = {3'b000, ptrs_q.rdpt[12:8]};
          PBA_OFS_WRPT_L: rdata_d = ptrs_q.wrpt[7:0];
          PBA_OFS_WRPT_H: rdata_d = {3'b000, ptrs_q.wrpt[12:8]};
          PBA_OFS_RXST_L: rdata_d = ptrs_q.rxst[7:0];
          PBA_OFS_RXST_H: rdata_d = {3'b000, ptrs_q.rxst[12:8]};
          PBA_OFS_RXND_L: rdata_d = ptrs_q.rxnd[7:0];
          PBA_OFS_RXND_H: rdata_d = {3'b000, ptrs_q.rxnd[12:8]};
          PBA_OFS_CTRL_TWO: rdata_d = ctrl_q;
          // window byte from the buffer, unmapped reads give zero
          default: rdata_d = hit_win ? ram_rdata : 8'h00;
        endcase
      end
      PBA_ACC_WRITE: begin
        busy_d = hit_win;
        if (win_wr && pointer_auto_increment) begin
          ptrs_d.wrpt = step_ptr(ptrs_q.wrpt);
          // core's read-modify-write cycle reads the window too
          if (req.single_cycle) begin
            ptrs_d.rdpt = step_rd(ptrs_q.rdpt, ptrs_q.rxst,
                                  ptrs_q.rxnd);
          end
          // two-cycle moves leave the read pointer
        end
        // byte-wide registers program the pointers
        unique case (req.addr)
          PBA_OFS_RDPT_L: ptrs_d.rdpt = set_lo(ptrs_q.rdpt, req.wdata);
          PBA_OFS_RDPT_H: ptrs_d.rdpt = set_hi(ptrs_q.rdpt, req.wdata);
          PBA_OFS_WRPT_L: ptrs_d.wrpt = set_lo(ptrs_q.wrpt, req.wdata);
          PBA_OFS_WRPT_H: ptrs_d.wrpt = set_hi(ptrs_q.wrpt, req.wdata);
          PBA_OFS_RXST_L: ptrs_d.rxst = set_lo(ptrs_q.rxst, req.wdata);
          PBA_OFS_RXST_H: ptrs_d.rxst = set_hi(ptrs_q.rxst, req.wdata);
          PBA_OFS_RXND_L: ptrs_d.rxnd = set_lo(ptrs_q.rxnd, req.wdata);
          PBA_OFS_RXND_H: ptrs_d.rxnd = set_hi(ptrs_q.rxnd, req.wdata);
          PBA_OFS_CTRL_TWO: ctrl_d = {req.wdata[7:5], 5'b00000};
          default: ctrl_d = ctrl_q; // window or unmapped: nothing
        endcase
      end
      // both at once returns zero and writes nothing; the core must not do it
      PBA_ACC_RMW: begin
        rvalid_d = 1'b1;
        rdata_d = 8'h00;
      end
      PBA_ACC_NONE: rvalid_d = 1'b0;
    endcase
  end

  // register pointers and control
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ptrs_q <= '{rdpt: PBA_PTR_RST, wrpt: PBA_PTR_RST,
                  rxst: PBA_PTR_RST, rxnd: PBA_RXND_RST};
      ctrl_q <= PBA_CTRL_TWO_RST;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      win_rd_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (ce_i) begin
      ptrs_q <= ptrs_d;
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      win_rd_q <= win_rd_d;
      busy_q <= busy_d;
    end
  end

  // physical-layer bank: not in the core map, word wide
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      phy_rdata_q <= 16'h0000;
    end else if (ce_i) begin
      if (phy_wr_i) begin
        phy_bank_q[phy_addr_i] <= phy_wdata_i;
      end
      phy_rdata_q <= phy_bank_q[phy_addr_i];
    end
  end

  // read data, window byte included, leaves straight from its register
  assign bus_rdata_o = rdata_q;
  assign bus_rvalid_o = rvalid_q;
  assign phy_rdata_o = phy_rdata_q;
  assign module_enable_o = ctrl_q[PBA_CTL_ENABLE_BIT];
  assign window_busy_o = busy_q;

  // assertions
  a_win_write_step: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) (ce_i && win_wr && pointer_auto_increment) |=>
    (ptrs_q.wrpt == $past(ptrs_q.wrpt) + 13'h0001))
    else $error("write pointer did not advance by one");

  a_rd_wrap_start: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) (ce_i && win_rd && pointer_auto_increment &&
    ptrs_q.rdpt == ptrs_q.rxnd) |=> (ptrs_q.rdpt == $past(ptrs_q.rxst)))
    else $error("read pointer did not wrap to region start");

  a_single_cycle_rd: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) (ce_i && win_wr && pointer_auto_increment && req.single_cycle
    && ptrs_q.rdpt != ptrs_q.rxnd) |=>
    (ptrs_q.rdpt == $past(ptrs_q.rdpt) + 13'h0001))
    else $error("single-cycle write left read pointer");

  a_two_cycle_hold: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) (ce_i && win_wr && !req.single_cycle) |=>
    $stable(ptrs_q.rdpt))
    else $error("two-cycle write moved read pointer");

  a_noinc_hold: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) (ce_i && hit_win && req.rd && !req.wr
    && !pointer_auto_increment) |=> $stable(ptrs_q.rdpt))
    else $error("read pointer moved without auto-increment");

  a_wrpt_rollover: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) (ce_i && win_wr && pointer_auto_increment &&
    ptrs_q.wrpt == 13'h1FFF) |=> (ptrs_q.wrpt == 13'h0000))
    else $error("write pointer did not roll over");

  a_pointer_auto_increment_reset: assert property (@(posedge clk_sys_i)
    $fell(reset_i) |-> ctrl_q[PBA_CTL_POINTER_AUTO_INCREMENT_BIT])
    else $error("auto-increment not set after reset");

  // window read: request on one edge, buffer byte on the next
  sequence s_win_rd_req;
    ce_i && win_rd;
  endsequence
  sequence s_win_rd_ans;
    bus_rvalid_o && win_rd_q && (bus_rdata_o == $past(ram_rdata));
  endsequence

  a_win_read_data: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) s_win_rd_req |=> s_win_rd_ans)
    else $error("window read not answered from buffer");

endmodule // pba_access_port

//--- tb/pba_core_model.sv
// core-side register bus model for the access port bench
`timescale 1ns/1ps
module pba_core_model
  import pba_pkg::*;
(
  // clock
  input wire logic clk_sys_i,
  // register bus
  output pba_req_s req_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  int errs = 0; // answers that never came
  initial req_o = '0;
  // one write; rd stays low, so no access reads and writes at once
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic sc = 1'b0);
    @(posedge clk_sys_i); #1;
    req_o.wr = 1'b1;
    req_o.single_cycle = sc;
    req_o.addr = a;
    req_o.wdata = d;
    @(posedge clk_sys_i); #1;
    // released lines do not keep their last value
    req_o = '{rd: 1'b0, wr: 1'b0, single_cycle: 1'b0,
              addr: ~a, wdata: ~d};
  endtask
  // one read; the byte is taken with rvalid, four cycles at most
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    int n;
    @(posedge clk_sys_i); #1;
    req_o.rd = 1'b1;
    req_o.addr = a;
    @(posedge clk_sys_i); #1;
    req_o.rd = 1'b0;
    req_o.addr = ~a;
    n = 0;
    while (rvalid_i !== 1'b1 && n < 4) begin
      @(posedge clk_sys_i); #1;
      n++;
    end
    if (n == 4) begin
      errs++;
    end
    d = rdata_i;
  endtask
endmodule // pba_core_model

//--- tb/test_pba_access_port.sv
// self-checking bench for the packet buffer access port
`timescale 1ns/1ps
module test_pba_access_port;
  import pba_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic phy_wr = 1'b0;
  logic [4:0] phy_addr = 5'h03;
  logic [15:0] phy_wdata = 16'h0000;
  logic [15:0] phy_rdata;
  logic [7:0] rdata;
  logic rvalid, mod_en;
  logic busy;
  pba_req_s req;
  int fails = 0;
  int check_count = 0;
  logic [7:0] b;
  logic [12:0] p;
  // 100 MHz system clock
  always #5 clk_sys_i = ~clk_sys_i;
  pba_core_model core (.clk_sys_i(clk_sys_i), .req_o(req),
    .rdata_i(rdata), .rvalid_i(rvalid));
  pba_access_port dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .ce_i(1'b1), .bus_rd_i(req.rd), .bus_wr_i(req.wr),
    .bus_single_cycle_i(req.single_cycle), .bus_addr_i(req.addr),
    .bus_wdata_i(req.wdata), .bus_rdata_o(rdata), .bus_rvalid_o(rvalid),
    .phy_wr_i(phy_wr), .phy_addr_i(phy_addr), .phy_wdata_i(phy_wdata),
    .phy_rdata_o(phy_rdata), .module_enable_o(mod_en),
    .window_busy_o(busy));
  // compare one value, count it, report a mismatch at once
  task automatic chk(input string what, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // pointers travel as two bytes, low first
  task automatic setp(input logic [11:0] lo, input logic [12:0] v);
    core.wr(lo, v[7:0]);
    core.wr(lo + 12'h001, {3'b000, v[12:8]});
  endtask
  task automatic getp(input logic [11:0] lo, output logic [12:0] v);
    logic [7:0] l, h;
    core.rd(lo, l);
    core.rd(lo + 12'h001, h);
    v = {h[4:0], l};
  endtask
  task automatic t_reset();
    core.rd(PBA_OFS_CTRL_TWO, b);
    chk("control", b, 16'h0080);
    getp(PBA_OFS_RXND_L, p);
    chk("rx end", p, 16'h1FFF);
    core.rd(12'h000, b);
    chk("unmapped", b, 16'h0000);
    $display("reset values done");
  endtask
  // two-cycle writes step only the write pointer
  task automatic t_window();
    setp(PBA_OFS_RDPT_L, 13'h0100);
    setp(PBA_OFS_WRPT_L, 13'h0010);
    for (int i = 0; i < 3; i++) core.wr(PBA_OFS_DATA_WINDOW, 8'hA0 + i);
    getp(PBA_OFS_WRPT_L, p);
    chk("wrpt", p, 16'h0013);
    getp(PBA_OFS_RDPT_L, p);
    chk("rdpt", p, 16'h0100);
    setp(PBA_OFS_RDPT_L, 13'h0010);
    for (int i = 0; i < 3; i++) begin
      core.rd(PBA_OFS_DATA_WINDOW, b);
      chk("byte", b, 16'h00A0 + i);
      chk("busy", {15'h0000, busy}, 16'h0001);
    end
    getp(PBA_OFS_RDPT_L, p);
    chk("rdpt", p, 16'h0013);
    chk("idle busy", {15'h0000, busy}, 16'h0000);
    $display("window done");
  endtask
  task automatic t_wrap();
    setp(PBA_OFS_RXST_L, 13'h0020);
    setp(PBA_OFS_RXND_L, 13'h0022);
    setp(PBA_OFS_WRPT_L, 13'h0021);
    core.wr(PBA_OFS_DATA_WINDOW, 8'h5A);
    core.wr(PBA_OFS_DATA_WINDOW, 8'hA5);
    core.wr(PBA_OFS_DATA_WINDOW, 8'h3C);
    getp(PBA_OFS_WRPT_L, p);
    chk("wrpt", p, 16'h0024);
    setp(PBA_OFS_RDPT_L, 13'h0021);
    core.rd(PBA_OFS_DATA_WINDOW, b);
    chk("byte", b, 16'h005A);
    core.rd(PBA_OFS_DATA_WINDOW, b);
    chk("end byte", b, 16'h00A5);
    getp(PBA_OFS_RDPT_L, p);
    chk("rdpt", p, 16'h0020);
    $display("wrap done");
  endtask
  task automatic t_single();
    setp(PBA_OFS_RDPT_L, 13'h0040);
    setp(PBA_OFS_WRPT_L, 13'h0050);
    core.wr(PBA_OFS_DATA_WINDOW, 8'h11, 1'b1);
    getp(PBA_OFS_RDPT_L, p);
    chk("rdpt", p, 16'h0041);
    getp(PBA_OFS_WRPT_L, p);
    chk("wrpt", p, 16'h0051);
    $display("single-cycle done");
  endtask
  // auto-increment off, module enabled: pointers hold
  task automatic t_noinc();
    core.wr(PBA_OFS_CTRL_TWO, 8'h20);
    setp(PBA_OFS_RDPT_L, 13'h0050);
    core.rd(PBA_OFS_DATA_WINDOW, b);
    chk("enable", {15'h0000, mod_en}, 16'h0001);
    chk("byte", b, 16'h0011);
    core.wr(PBA_OFS_DATA_WINDOW, 8'h22);
    getp(PBA_OFS_RDPT_L, p);
    chk("rdpt", p, 16'h0050);
    getp(PBA_OFS_WRPT_L, p);
    chk("wrpt", p, 16'h0051);
    core.wr(PBA_OFS_CTRL_TWO, 8'h80);
    $display("no-increment done");
  endtask
  task automatic t_roll();
    setp(PBA_OFS_WRPT_L, 13'h1FFF);
    core.wr(PBA_OFS_DATA_WINDOW, 8'h77);
    getp(PBA_OFS_WRPT_L, p);
    chk("wrpt", p, 16'h0000);
    setp(PBA_OFS_RDPT_L, 13'h1FFF);
    core.rd(PBA_OFS_DATA_WINDOW, b);
    chk("top byte", b, 16'h0077);
    getp(PBA_OFS_RDPT_L, p);
    chk("rdpt", p, 16'h0000);
    @(posedge clk_sys_i); #1;
    phy_wr = 1'b1;
    phy_wdata = 16'hBEEF;
    @(posedge clk_sys_i); #1;
    phy_wr = 1'b0;
    @(posedge clk_sys_i); #1;
    chk("phy word", phy_rdata, 16'hBEEF);
    $display("rollover done");
  endtask
  task automatic close_out();
    fails += core.errs;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    #1 reset_i = 1'b0;
    t_reset();
    t_window();
    t_wrap();
    t_single();
    t_noinc();
    t_roll();
    close_out();
  end
  // cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    close_out();
  end
endmodule // test_pba_access_port
